// file: rmii_phy_data_interface.v
// Transceiver-side reduced media independent dibit data interface
`timescale 1ns/1ps
`default_nettype none
`include "rmii_phy_regs.vh"

module rmii_phy_data_interface #(
  parameter FIFO_DEPTH = 32,
  parameter FIFO_ADDR_W = 5,
  parameter NCO_W = 16
) (
  // Clock and reset
  input wire i_clock,
  input wire i_rst,
  // Straps and clock-mode selection
  input wire [2:0] i_config,
  input wire i_clk_mode_50,
  // Crystal clock pin and reference clock pin
  input wire i_crystal_clock_input,
  output reg o_ref_clk,
  output reg o_ref_clk_oe_n,
  // Transmit group from the MAC
  input wire i_tx_en,
  input wire [1:0] i_txd,
  // Receive group to the MAC
  output reg o_crs_dv,
  output reg [1:0] o_rxd,
  output reg o_rx_er,
  // Line side link status
  input wire i_speed_100,
  input wire i_eee_lpi,
  input wire i_line_carrier,
  // Line side receive stream
  input wire i_line_rx_valid,
  input wire [1:0] i_line_rx_dibit,
  input wire i_line_rx_error,
  output wire o_line_rx_ready,
  // Line side transmit stream
  output reg o_line_tx_valid,
  output reg [1:0] o_line_tx_dibit,
  output reg o_line_tx_lpi,
  // Latched mode
  output reg o_rmii_mode,
  output reg o_nibble_mode,
  output reg o_repeater_mode,
  output reg o_clk_mode_ext
);

  // NCO step for reference clock from system clock, 64-bit to avoid overflow
  localparam [63:0] NCO_STEP_WIDE = (`REF_CLK_KHZ << NCO_W) / `SYS_CLK_KHZ;
  localparam [NCO_W-1:0] NCO_STEP = NCO_STEP_WIDE[NCO_W-1:0];

  localparam [1:0] RX_IDLE = 2'h0;
  localparam [1:0] RX_WAIT = 2'h1;
  localparam [1:0] RX_DATA = 2'h2;

  // ==========================================================================
  // Synchronisers for pins from outside the clock domain
  reg [2:0] cfg_s1;
  reg [2:0] cfg_s2;
  reg mode_s1;
  reg mode_s2;
  reg xi_s1;
  reg xi_s2;
  reg xi_d;
  reg txen_s1;
  reg txen_s2;
  reg [1:0] txd_s1;
  reg [1:0] txd_s2;

  // Pins only feed the first stage; logic reads stage two
  always @(posedge i_clock) begin
    cfg_s1 <= i_config;
    cfg_s2 <= cfg_s1;
    mode_s1 <= i_clk_mode_50;
    mode_s2 <= mode_s1;
    xi_s1 <= i_crystal_clock_input;
    xi_s2 <= xi_s1;
    xi_d <= xi_s2;
    txen_s1 <= i_tx_en;
    txen_s2 <= txen_s1;
    txd_s1 <= i_txd;
    txd_s2 <= txd_s1;
  end

  // ==========================================================================
  // Strap latch
  reg [1:0] settle;
  reg strap_done;

  // Straps pass the synchroniser first, then are frozen until next reset
  always @(posedge i_clock) begin
    if (i_rst) begin
      settle <= 2'h0;
      strap_done <= 1'b0;
      o_rmii_mode <= 1'b0;
      o_nibble_mode <= 1'b0;
      o_repeater_mode <= 1'b0;
      o_clk_mode_ext <= 1'b0;
    end else if (!strap_done) begin
      settle <= settle + 2'h1;
      if (settle == `STRAP_SETTLE) begin
        strap_done <= 1'b1;
        o_rmii_mode <= (cfg_s2 == `CFG_RMII) | (cfg_s2 == `CFG_RMII_B2B);
        o_nibble_mode <= (cfg_s2 == `CFG_MII) | (cfg_s2 == `CFG_MII_B2B);
        o_repeater_mode <= (cfg_s2 == `CFG_RMII_B2B) | (cfg_s2 == `CFG_MII_B2B);
        // Strap 110 shares one crystal between the pair, so it never selects
        // the external reference even when the mode pin is high
        o_clk_mode_ext <= mode_s2 & (cfg_s2 != `CFG_MII_B2B);
      end
    end
  end

  // ==========================================================================
  // Reference clock generation and edge finding
  reg [NCO_W-1:0] nco;
  reg nco_msb_d;
  reg ref_tick;

  // Crystal mode synthesises the reference with an NCO; edges jitter by one
  // system period, a limit of deriving 50 MHz from 125 MHz
  always @(posedge i_clock) begin
    if (i_rst) begin
      nco <= {NCO_W{1'b0}};
      nco_msb_d <= 1'b0;
      ref_tick <= 1'b0;
      o_ref_clk <= 1'b0;
      o_ref_clk_oe_n <= 1'b1;
    end else begin
      nco <= nco + NCO_STEP;
      nco_msb_d <= nco[NCO_W-1];
      if (o_clk_mode_ext) begin
        ref_tick <= xi_s2 & ~xi_d;
        o_ref_clk <= 1'b0;
        o_ref_clk_oe_n <= 1'b1;
      end else begin
        ref_tick <= nco[NCO_W-1] & ~nco_msb_d;
        // Pin stays low until the straps are known, so no pulse escapes
        // in a mode that later turns out to leave the pin unused
        o_ref_clk <= nco[NCO_W-1] & strap_done & o_rmii_mode;
        o_ref_clk_oe_n <= ~(strap_done & o_rmii_mode);
      end
    end
  end

  // ==========================================================================
  // Line rate divider: at 10 Mb/s each dibit spans ten reference periods
  reg [3:0] rate_cnt;
  wire [3:0] rate_top = i_speed_100 ? `RATE_DIV_100M : `RATE_DIV_10M;
  // Every transmit sample and in-frame receive update waits for a slot, idle codes a
  // reference tick, so apart from the o_crs_dv rise the MAC sees pins move at most once per reference period
  wire slot = ref_tick & (rate_cnt == 4'h0) & o_rmii_mode;

  always @(posedge i_clock) begin
    if (i_rst) begin
      rate_cnt <= 4'h0;
    end else if (ref_tick) begin
      rate_cnt <= (rate_cnt >= rate_top) ? 4'h0 : rate_cnt + 4'h1;
    end
  end

  // ==========================================================================
  // Transmit path: one MAC dibit per slot to the line
  always @(posedge i_clock) begin
    if (i_rst) begin
      o_line_tx_valid <= 1'b0;
      o_line_tx_dibit <= `DIBIT_IDLE;
      o_line_tx_lpi <= 1'b0;
    end else if (slot) begin
      o_line_tx_valid <= txen_s2;
      o_line_tx_dibit <= txen_s2 ? txd_s2 : `DIBIT_IDLE;
      o_line_tx_lpi <= ~txen_s2 & (txd_s2 == `DIBIT_LPI);
    end else begin
      o_line_tx_valid <= 1'b0;
      o_line_tx_lpi <= 1'b0;
    end
  end

  // ==========================================================================
  // Receive buffer between line recovery and the MAC-facing pins
  // Recovery may outrun a ten megabit drain; ready tells it to stall
  wire fifo_out_valid;
  wire [2:0] fifo_out_data;
  reg fifo_pop;

  rmii_dibit_fifo #(
    .WIDTH(3),
    .DEPTH(FIFO_DEPTH),
    .ADDR_W(FIFO_ADDR_W)
  ) u_rx_fifo (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_in_valid(i_line_rx_valid),
    .i_in_data({i_line_rx_error, i_line_rx_dibit}),
    .o_in_ready(o_line_rx_ready),
    .o_out_valid(fifo_out_valid),
    .o_out_data(fifo_out_data),
    .i_out_ready(fifo_pop)
  );

  // ==========================================================================
  // Receive state machine
  reg [1:0] rx_state;
  reg [1:0] next_rx_state;
  reg err_pend;
  wire [1:0] idle_code = i_eee_lpi ? `DIBIT_LPI : `DIBIT_IDLE;

  // Pop one entry per slot once decoded data is waiting
  // Carrier loss only ends a frame once the buffer has run dry
  always @* begin
    fifo_pop = 1'b0;
    next_rx_state = rx_state;
    case (rx_state)
      RX_IDLE: begin
        if (i_line_carrier & o_rmii_mode) begin
          next_rx_state = RX_WAIT;
        end
      end
      RX_WAIT: begin
        if (slot & fifo_out_valid) begin
          fifo_pop = 1'b1;
          next_rx_state = RX_DATA;
        end else if (slot & ~i_line_carrier) begin
          next_rx_state = RX_IDLE;
        end
      end
      RX_DATA: begin
        if (slot & fifo_out_valid) begin
          fifo_pop = 1'b1;
        end else if (slot & ~i_line_carrier) begin
          next_rx_state = RX_IDLE;
        end
      end
      default: begin
        next_rx_state = RX_IDLE;
      end
    endcase
  end

  // Pins change only on reference ticks, frame data only on slots, except the carrier-driven rise
  always @(posedge i_clock) begin
    if (i_rst) begin
      rx_state <= RX_IDLE;
      o_crs_dv <= 1'b0;
      o_rxd <= `DIBIT_IDLE;
      o_rx_er <= 1'b0;
      err_pend <= 1'b0;
    end else begin
      rx_state <= next_rx_state;
      if (rx_state == RX_IDLE && next_rx_state == RX_WAIT) begin
        o_crs_dv <= 1'b1;
        o_rxd <= `DIBIT_IDLE;
      end else if (slot) begin
        if (fifo_pop) begin
          o_rxd <= fifo_out_data[1:0];
          o_rx_er <= fifo_out_data[2] | err_pend;
          err_pend <= 1'b0;
        end else if (next_rx_state == RX_IDLE) begin
          o_crs_dv <= 1'b0;
          o_rxd <= idle_code;
          o_rx_er <= 1'b0;
          err_pend <= 1'b0;
        end else begin
          o_rxd <= (rx_state == RX_IDLE) ? idle_code : `DIBIT_IDLE;
          o_rx_er <= err_pend;
          err_pend <= 1'b0;
        end
      end else if (ref_tick & (rx_state == RX_IDLE)) begin
        o_rxd <= o_rmii_mode ? idle_code : `DIBIT_IDLE;
      end
      // An errored word refused by a full buffer never reaches the pins, so
      // its error is held and shown at the next slot instead; accepted words
      // carry their own error bit through the buffer to the right dibit
      if (i_line_rx_valid & ~o_line_rx_ready & i_line_rx_error & (rx_state != RX_IDLE)) begin
        err_pend <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// file: rmii_phy_regs.vh
// Constants for the reduced-interface dibit data path of the transceiver
`ifndef RMII_PHY_REGS_VH
`define RMII_PHY_REGS_VH

// ==========================================================================
// Configuration strap codes
`define CFG_MII 3'h0
`define CFG_RMII 3'h1
`define CFG_RMII_B2B 3'h5
`define CFG_MII_B2B 3'h6

// ==========================================================================
// Dibit line codes
`define DIBIT_IDLE 2'h0
`define DIBIT_LPI 2'h1

// ==========================================================================
// Rate and timing
`define SYS_CLK_KHZ 64'h0000_0000_0001_E848
`define REF_CLK_KHZ 64'h0000_0000_0000_C350
`define RATE_DIV_10M 4'h9
`define RATE_DIV_100M 4'h0
`define STRAP_SETTLE 2'h3

`endif

// file: rmii_dibit_fifo.v
// Synchronous FIFO with valid/ready on both sides for received dibits
`timescale 1ns/1ps
`default_nettype none

module rmii_dibit_fifo #(
  parameter WIDTH = 3,
  parameter DEPTH = 32,
  parameter ADDR_W = 5
) (
  // Clock and reset
  input wire i_clock,
  input wire i_rst,
  // Fill side
  input wire i_in_valid,
  input wire [WIDTH-1:0] i_in_data,
  output reg o_in_ready,
  // Drain side
  output reg o_out_valid,
  output wire [WIDTH-1:0] o_out_data,
  input wire i_out_ready
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [ADDR_W-1:0] wr_ptr;
  reg [ADDR_W-1:0] rd_ptr;
  reg [ADDR_W:0] count;
  wire push = i_in_valid & o_in_ready;
  wire pop = o_out_valid & i_out_ready;
  wire [ADDR_W:0] next_count = count + {{ADDR_W{1'b0}}, push} - {{ADDR_W{1'b0}}, pop};

  assign o_out_data = mem[rd_ptr];

  // ==========================================================================
  // Pointers and flags; full and empty are flops so ready never glitches
  always @(posedge i_clock) begin
    if (i_rst) begin
      wr_ptr <= {ADDR_W{1'b0}};
      rd_ptr <= {ADDR_W{1'b0}};
      count <= {(ADDR_W+1){1'b0}};
      o_in_ready <= 1'b0;
      o_out_valid <= 1'b0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= i_in_data;
        wr_ptr <= (wr_ptr == DEPTH - 1) ? {ADDR_W{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH - 1) ? {ADDR_W{1'b0}} : rd_ptr + 1'b1;
      end
      count <= next_count;
      o_in_ready <= (next_count != DEPTH);
      o_out_valid <= (next_count != {(ADDR_W+1){1'b0}});
    end
  end

endmodule

`default_nettype wire

// file: rmii_mac_model.sv
// Behavioural MAC transmit side that also makes the external reference clock
`timescale 1ns/1ps
`default_nettype none
module rmii_mac_model (
  // Reference clock and transmit group
  output logic o_ref,
  output logic o_tx_en,
  output logic [1:0] o_txd,
  // Low-power idle request
  input wire logic i_eee
);
  // Dibits still to send; the bench loads whole frames at once
  logic [1:0] frame_q[$];
  // ==========================================================================
  // Free-running clock of 125 ns, offset so it never lines up with the system clock
  initial begin
    o_ref = 1'b0;
    o_tx_en = 1'b0;
    o_txd = 2'h0;
    #3.1;
    forever #62.5 o_ref = ~o_ref;
  end
  // Lines move on the falling edge so they sit still across the rising one
  always @(negedge o_ref) begin
    if (frame_q.size() > 0) begin
      o_tx_en <= 1'b1;
      o_txd <= frame_q.pop_front();
    end else begin
      o_tx_en <= 1'b0;
      o_txd <= {1'b0, i_eee};
    end
  end
endmodule
`default_nettype wire

// file: rmii_phy_data_interface_monitor.sv
// Port checker of the dibit data interface
`timescale 1ns/1ps
`default_nettype none
module rmii_phy_data_interface_monitor (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Watched ports
  input wire logic i_line_carrier,
  input wire logic i_eee_lpi,
  input wire logic o_ref_clk,
  input wire logic o_ref_clk_oe_n,
  input wire logic o_crs_dv,
  input wire logic [1:0] o_rxd,
  input wire logic o_rx_er,
  input wire logic o_line_tx_valid,
  input wire logic o_line_tx_lpi,
  input wire logic o_rmii_mode,
  input wire logic o_nibble_mode,
  input wire logic o_clk_mode_ext
);
  // ==========================================================================
  // Cycles since reset, saturating; modes settle by the fourth edge
  logic [3:0] up_cnt;
  always @(posedge i_clock) begin
    up_cnt <= i_rst ? 4'h0 : up_cnt + {3'h0, up_cnt != 4'hf};
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // ==========================================================================
  // Port relations
  chk_oe_crystal: assert property (!o_ref_clk_oe_n |-> o_rmii_mode && !o_clk_mode_ext)
    else $error("ref clock driven outside crystal mode");
  chk_ref_quiet: assert property (o_clk_mode_ext |-> o_ref_clk_oe_n && !o_ref_clk)
    else $error("ref clock active in external mode");
  chk_crs_prompt: assert property ($rose(i_line_carrier) && o_rmii_mode && !o_crs_dv |=> o_crs_dv)
    else $error("carrier not flagged next cycle");
  chk_rise_zero: assert property ($rose(o_crs_dv) |-> o_rxd == 2'h0)
    else $error("receive dibit not zero at valid rise");
  chk_rxd_paced: assert property ($changed(o_rxd) && !$rose(o_crs_dv) |=> $stable(o_rxd))
    else $error("receive dibit moved twice in a row");
  chk_idle_code: assert property ($fell(o_crs_dv) |-> o_rxd == {1'b0, $past(i_eee_lpi)})
    else $error("wrong idle code after frame");
  chk_err_valid: assert property ($rose(o_rx_er) |-> o_crs_dv)
    else $error("receive error outside frame");
  chk_tx_pulse: assert property (o_line_tx_valid |-> !o_line_tx_lpi ##1 !o_line_tx_valid)
    else $error("transmit pulse malformed");
  chk_mode_hold: assert property (up_cnt > 4'h6 |-> $stable({o_rmii_mode, o_clk_mode_ext}))
    else $error("mode changed without reset");
  chk_mode_excl: assert property (o_rmii_mode |-> !o_nibble_mode)
    else $error("dibit and nibble mode together");
  // Main scenarios reached
  cov_frame_end: cover property ($fell(o_crs_dv));
  cov_rx_err: cover property (o_rx_er && o_crs_dv);
  cov_tx_dibit: cover property (o_line_tx_valid);
endmodule
bind rmii_phy_data_interface rmii_phy_data_interface_monitor rmii_phy_data_interface_monitor_inst (
  .i_clock, .i_rst, .i_line_carrier, .i_eee_lpi, .o_ref_clk, .o_ref_clk_oe_n, .o_crs_dv,
  .o_rxd, .o_rx_er, .o_line_tx_valid, .o_line_tx_lpi, .o_rmii_mode, .o_nibble_mode,
  .o_clk_mode_ext);
`default_nettype wire

// file: rmii_phy_data_interface_tb.sv
// Self-checking bench of the dibit data interface against queue models
`timescale 1ns/1ps
`default_nettype none
module rmii_phy_data_interface_tb;
  // ==========================================================================
  // Design signals, all driven on the falling edge
  logic i_clock = 1'b0, i_rst = 1'b1, i_clk_mode_50 = 1'b0, i_speed_100 = 1'b1;
  logic i_eee_lpi = 1'b0, i_line_carrier = 1'b0, i_line_rx_valid = 1'b0, i_line_rx_error = 1'b0;
  logic [2:0] i_config = 3'h1;
  logic [1:0] i_line_rx_dibit = 2'h0, prev_rxd = 2'h0;
  wire xi, tx_en, o_ref_clk, o_ref_clk_oe_n, o_crs_dv, o_rx_er, o_line_rx_ready, o_line_tx_lpi;
  wire o_line_tx_valid, o_rmii_mode, o_nibble_mode, o_repeater_mode, o_clk_mode_ext;
  wire [1:0] txd, o_rxd, o_line_tx_dibit;
  int error_cnt = 0, checks = 0, taken = 0, lpi_cnt = 0, coll_cnt = 0;
  logic [31:0] seed = 32'h0000_04f2;
  logic [2:0] rx_q[$];
  logic [1:0] tx_q[$];
  rmii_phy_data_interface rmii_phy_data_interface_inst (.i_clock, .i_rst, .i_config,
    .i_clk_mode_50, .i_crystal_clock_input(xi), .o_ref_clk, .o_ref_clk_oe_n, .i_tx_en(tx_en),
    .i_txd(txd), .o_crs_dv, .o_rxd, .o_rx_er, .i_speed_100, .i_eee_lpi, .i_line_carrier,
    .i_line_rx_valid, .i_line_rx_dibit, .i_line_rx_error, .o_line_rx_ready, .o_line_tx_valid,
    .o_line_tx_dibit, .o_line_tx_lpi, .o_rmii_mode, .o_nibble_mode, .o_repeater_mode,
    .o_clk_mode_ext);
  rmii_mac_model rmii_mac_model_inst (.o_ref(xi), .o_tx_en(tx_en), .o_txd(txd), .i_eee(i_eee_lpi));
  // 125 MHz system clock
  always #4 i_clock = ~i_clock;
  // ==========================================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic compare(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // A wait that ran out ends the run
  task automatic bound(input bit stuck);
    if (stuck) begin
      compare(8'h1, 8'h0);
      test_done();
    end
  endtask
  // Straps are only taken at reset release, so every mode needs a reset
  task automatic restart(input logic [2:0] cfg, input logic clk50);
    @(negedge i_clock);
    i_config = cfg;
    i_clk_mode_50 = clk50;
    i_rst = 1'b1;
    repeat (4) @(negedge i_clock);
    i_rst = 1'b0;
    repeat (40) @(negedge i_clock);
  endtask
  // Consecutive dibits always differ so each delivered one is visible
  task automatic rx_frame(input int len, input int err_at);
    logic [1:0] d = 2'h0;
    i_line_carrier = 1'b1;
    for (int i = 0; i < len; i++) begin
      d = d ^ (2'h1 + 2'(rnd() % 3));
      @(negedge i_clock);
      i_line_rx_valid = 1'b1;
      {i_line_rx_error, i_line_rx_dibit} = {i == err_at, d};
      @(posedge i_clock);
      if (!o_line_rx_ready) break;
      rx_q.push_back({i == err_at, d});
      taken++;
    end
    @(negedge i_clock);
    i_line_rx_valid = 1'b0;
    i_line_carrier = 1'b0;
  endtask
  // Each new dibit under data valid must be the next one sent
  always @(posedge i_clock) begin
    if (!i_rst && o_crs_dv && o_rxd !== prev_rxd)
      compare(8'({o_rx_er, o_rxd}), rx_q.size() > 0 ? 8'(rx_q.pop_front()) : 8'hff);
    if (o_line_tx_valid)
      compare(8'(o_line_tx_dibit), tx_q.size() > 0 ? 8'(tx_q.pop_front()) : 8'hff);
    // Low-power idle may only reach the line while the MAC asks for it
    if (o_line_tx_lpi)
      compare(8'(i_eee_lpi), 8'h1);
    lpi_cnt <= lpi_cnt + int'(o_line_tx_lpi);
    // The MAC side builds its own collision from its enable and valid
    coll_cnt <= coll_cnt + int'(tx_en && o_crs_dv);
    prev_rxd <= o_rxd;
  end
  // ==========================================================================
  // Scenarios
  initial begin
    logic [3:0] cases [5] = '{4'h0, 4'h2, 4'h3, 4'hb, 4'hc};
    logic [2:0] c;
    logic p;
    int n;
    foreach (cases[k]) begin
      restart(cases[k][3:1], cases[k][0]);
      c = cases[k][3:1];
      compare({3'h0, o_rmii_mode, o_nibble_mode, o_repeater_mode, o_clk_mode_ext, o_ref_clk_oe_n},
        {3'h0, c == 3'h1 || c == 3'h5, c == 3'h0 || c == 3'h6, c[2], cases[k][0] && c != 3'h6,
        !((c == 3'h1 || c == 3'h5) && !cases[k][0])});
      n = 0;
      p = o_ref_clk;
      repeat (250) begin
        @(negedge i_clock);
        n += int'(o_ref_clk && !p);
        p = o_ref_clk;
      end
      if (cases[k] == 4'h2) compare(8'(n >= 99 && n <= 101), 8'h1);
      else compare(8'(n), 8'h0);
    end
    $display("strap and clock modes done");
    restart(3'h1, 1'b1);
    for (int i = 0; i < 24 + int'(rnd() % 8); i++) begin
      tx_q.push_back(2'(seed));
      rmii_mac_model_inst.frame_q.push_back(2'(seed));
      void'(rnd());
    end
    rx_frame(6 + int'(rnd() % 20), 3);
    for (n = 0; n < 3000 && (rx_q.size() > 0 || tx_q.size() > 0 || o_crs_dv); n++)
      @(negedge i_clock);
    bound(n == 3000);
    compare(8'(o_rxd), 8'h0);
    compare(8'(coll_cnt > 0), 8'h1);
    $display("full rate frames done");
    i_speed_100 = 1'b0;
    taken = 0;
    rx_frame(40, 40);
    compare(8'(taken >= 32 && taken < 40), 8'h1);
    i_eee_lpi = 1'b1;
    for (n = 0; n < 9000 && (rx_q.size() > 0 || o_crs_dv); n++) @(negedge i_clock);
    bound(n == 9000);
    compare(8'(o_rxd), 8'h1);
    compare(8'(lpi_cnt > 0), 8'h1);
    $display("ten megabit fill and drain done");
    test_done();
  end
endmodule
`default_nettype wire
